// ===== qot_pkg.sv
package qot_pkg;

    localparam int unsigned QOT_CNT_W = 16;
    localparam logic [QOT_CNT_W-1:0] QOT_CNT_MAX = 16'hffff;
    localparam logic [QOT_CNT_W-1:0] QOT_CNT_ZERO = 16'h0000;
    localparam logic [QOT_CNT_W-1:0] QOT_CNT_ONE = 16'h0001;
    localparam logic [QOT_CNT_W-1:0] QOT_TIMER_RESET = 16'h0000;

    localparam int unsigned QOT_ADDR_W = 8;
    localparam logic [QOT_ADDR_W-1:0] QOT_OFS_TIMER = 8'h00;
    localparam logic [QOT_ADDR_W-1:0] QOT_OFS_CTRL = 8'h04;
    localparam logic [QOT_ADDR_W-1:0] QOT_OFS_STATUS = 8'h08;

    localparam int unsigned QOT_CTRL_FIELDS_W = 9;
    localparam int unsigned QOT_CTRL_OSSTART = 9;
    localparam int unsigned QOT_STATUS_W = 3;

    localparam logic [4:0] QOT_DIV8_LAST = 5'h07;
    localparam logic [4:0] QOT_DIV32_LAST = 5'h1f;

    typedef enum logic [0:0] {
        QOT_MODE_TWOPHASE = 1'b0,
        QOT_MODE_ONESHOT = 1'b1
    } qot_mode_type;

    typedef enum logic [1:0] {
        QOT_SRC_DIV1 = 2'h0,
        QOT_SRC_DIV8 = 2'h1,
        QOT_SRC_DIV32 = 2'h2,
        QOT_SRC_SUB32 = 2'h3
    } qot_src_type;

    typedef enum logic [1:0] {
        QOT_TRIG_SOFT = 2'h0,
        QOT_TRIG_PIN = 2'h1,
        QOT_TRIG_OVF = 2'h2,
        QOT_TRIG_NONE = 2'h3
    } qot_trig_type;

    // Bits [8:0] of the control register, start flag in bit 0
    typedef struct packed {
        qot_trig_type trigSel;
        logic pulseEn;
        qot_src_type srcSel;
        logic x4Sel;
        logic freeRun;
        qot_mode_type mode;
        logic start;
    } qot_ctrl_type;

    localparam qot_ctrl_type QOT_CTRL_RESET = 9'h000;

    typedef enum logic [3:0] {
        QOT_ST_STOP = 4'b0001,
        QOT_ST_COUNT = 4'b0010,
        QOT_ST_ARMED = 4'b0100,
        QOT_ST_SHOT = 4'b1000
    } qot_state_type;

endpackage

// ===== qot_timer.sv
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none

module qot_timer #(
    parameter int CHANNEL_INDEX = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic timerInputPin,
    input wire logic timerOutPinIn,
    output logic timerOutPinOut,
    output logic timerOutPinOe,
    input wire logic subClock,
    input wire logic otherTimerOverflow,
    output logic irqRequest
);
    import qot_pkg::*;

    generate
        if (CHANNEL_INDEX < 2 || CHANNEL_INDEX > 4) begin : badChannel
            $error("qot_timer: two-phase channel index must be 2, 3 or 4");
        end
    endgenerate

    localparam bit X4_SELECTABLE = (CHANNEL_INDEX == 3);
    localparam bit X4_FIXED = (CHANNEL_INDEX == 4);

    // Pin synchronisers and edge history
    logic [1:0] inSync;
    logic [1:0] outSync;
    logic [1:0] subSync;
    logic prevA;
    logic prevB;
    logic prevSub;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            inSync <= 2'b00;
            outSync <= 2'b00;
            subSync <= 2'b00;
        end else begin
            inSync <= {inSync[0], timerInputPin};
            outSync <= {outSync[0], timerOutPinIn};
            subSync <= {subSync[0], subClock};
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prevA <= 1'b0;
            prevB <= 1'b0;
            prevSub <= 1'b0;
        end else begin
            prevA <= inSync[1];
            prevB <= outSync[1];
            prevSub <= subSync[1];
        end
    end

    wire logic curA = inSync[1];
    wire logic curB = outSync[1];
    wire logic aEdge = curA ^ prevA;
    wire logic bEdge = curB ^ prevB;
    wire logic aRise = curA & ~prevA;
    wire logic subRise = subSync[1] & ~prevSub;

    // Count source prescalers
    logic [4:0] preCount;
    logic [4:0] subCount;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            preCount <= 5'h00;
            subCount <= 5'h00;
        end else begin
            preCount <= preCount + 5'h01;
            if (subRise) begin
                subCount <= subCount + 5'h01;
            end
        end
    end

    wire logic tickDiv8 = (preCount[2:0] == QOT_DIV8_LAST[2:0]);
    wire logic tickDiv32 = (preCount == QOT_DIV32_LAST);
    wire logic tickSub32 = subRise & (subCount == QOT_DIV32_LAST);

    // Registers
    qot_ctrl_type ctrl;
    qot_state_type state;
    qot_state_type next_state;
    logic [QOT_CNT_W-1:0] count;
    logic [QOT_CNT_W-1:0] next_count;
    logic [QOT_CNT_W-1:0] reload;
    logic [QOT_CNT_W-1:0] next_reload;
    logic lastUp;

    wire qot_src_type srcSel = ctrl.srcSel;
    wire logic srcTick = (srcSel == QOT_SRC_DIV1) ? 1'b1 :
                         (srcSel == QOT_SRC_DIV8) ? tickDiv8 :
                         (srcSel == QOT_SRC_DIV32) ? tickDiv32 : tickSub32;

    // Two-phase decoding
    wire logic x4Active = X4_FIXED | (X4_SELECTABLE & ctrl.x4Sel);
    wire logic upNormal = aEdge & curA & curB;
    wire logic downNormal = aEdge & ~curA & curB;
    // Both pins moving in one sample is a lost phase step; dropped in times-four mode, while normal mode still counts the A edge
    wire logic aOnly = aEdge & ~bEdge;
    wire logic bOnly = bEdge & ~aEdge;
    // Times-four step: {up, down} from the new levels and which pin moved
    function automatic logic [1:0] x4Step(
        input logic a,
        input logic b,
        input logic aMoved,
        input logic bMoved
    );
        logic same;
        same = (a == b);
        return {(aMoved & same) | (bMoved & ~same), (aMoved & ~same) | (bMoved & same)};
    endfunction

    wire logic [1:0] x4Dir = x4Step(curA, curB, aOnly, bOnly);
    wire logic upX4 = x4Dir[1];
    wire logic downX4 = x4Dir[0];
    wire logic inCount = (state == QOT_ST_COUNT);
    wire logic quadUp = inCount & (x4Active ? upX4 : upNormal);
    wire logic quadDown = inCount & (x4Active ? downX4 : downNormal);

    // Bus slave, zero wait for writes, one wait for reads
    logic wrPend;
    logic rdPend;
    logic [QOT_ADDR_W-1:0] addrReg;

    // Register decode shared by the write strobes and the read mux
    function automatic logic hitReg(
        input logic [QOT_ADDR_W-1:0] addr,
        input logic [QOT_ADDR_W-1:0] offset
    );
        return addr == offset;
    endfunction

    wire logic takeReq = hsel & htrans[1] & hready;
    wire logic selTimer = hitReg(addrReg, QOT_OFS_TIMER);
    wire logic selCtrl = hitReg(addrReg, QOT_OFS_CTRL);
    wire logic selStatus = hitReg(addrReg, QOT_OFS_STATUS);
    wire logic wrTimer = wrPend & selTimer;
    wire logic wrCtrl = wrPend & selCtrl;
    wire logic osStartPulse = wrCtrl & hwdata[QOT_CTRL_OSSTART];

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPend <= 1'b0;
            rdPend <= 1'b0;
            addrReg <= QOT_OFS_TIMER;
        end else if (hreadyout) begin
            wrPend <= takeReq & hwrite;
            rdPend <= takeReq & ~hwrite;
            if (takeReq) begin
                addrReg <= haddr[QOT_ADDR_W-1:0];
            end
        end else begin
            rdPend <= 1'b0;
        end
    end

    assign hreadyout = ~rdPend;
    assign hresp = 1'b0;

    wire logic running = (state == QOT_ST_COUNT) | (state == QOT_ST_SHOT);
    wire logic [QOT_STATUS_W-1:0] statusWord = {lastUp, timerOutPinOut, running};
    wire qot_ctrl_type ctrlRead = '{
        trigSel: ctrl.trigSel,
        pulseEn: ctrl.pulseEn,
        srcSel: ctrl.srcSel,
        x4Sel: ctrl.x4Sel & X4_SELECTABLE,
        freeRun: ctrl.freeRun,
        mode: ctrl.mode,
        start: ctrl.start
    };
    // Live count in two-phase mode; in one-shot the remaining down-count, reloaded at each trigger and at the shot end
    wire logic [31:0] readMux =
        selTimer ? {16'h0000, count} :
        selCtrl ? {23'h000000, ctrlRead} :
        selStatus ? {29'h0000000, statusWord} : 32'h00000000;

    // Sampled in the wait cycle so a preceding write is already visible
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (rdPend) begin
            hrdata <= readMux;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl <= QOT_CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl <= qot_ctrl_type'(hwdata[QOT_CTRL_FIELDS_W-1:0]);
        end
    end

    // One-shot triggers, all gated by the start flag through the state
    wire qot_trig_type trigSel = ctrl.trigSel;
    wire logic pinTrig = (trigSel == QOT_TRIG_PIN) & aRise;
    wire logic ovfTrig = (trigSel == QOT_TRIG_OVF) & otherTimerOverflow;
    wire logic trigger = osStartPulse | pinTrig | ovfTrig;
    wire logic shotTick = (state == QOT_ST_SHOT) & srcTick & ~trigger;
    wire logic shotEnd = shotTick & (count <= QOT_CNT_ONE);
    wire logic quadMode = ctrl.start & (ctrl.mode == QOT_MODE_TWOPHASE);
    wire logic shotMode = ctrl.start & (ctrl.mode == QOT_MODE_ONESHOT);

    always_comb begin
        next_state = state;
        case (state)
            QOT_ST_STOP: begin
                if (quadMode) begin
                    next_state = QOT_ST_COUNT;
                end else if (shotMode) begin
                    next_state = QOT_ST_ARMED;
                end
            end
            QOT_ST_COUNT: begin
                if (!quadMode) begin
                    next_state = QOT_ST_STOP;
                end
            end
            QOT_ST_ARMED: begin
                if (!shotMode) begin
                    next_state = QOT_ST_STOP;
                end else if (trigger) begin
                    next_state = QOT_ST_SHOT;
                end
            end
            QOT_ST_SHOT: begin
                if (!shotMode) begin
                    next_state = QOT_ST_STOP;
                end else if (shotEnd) begin
                    next_state = QOT_ST_ARMED;
                end
            end
            default: begin
                next_state = QOT_ST_STOP;
            end
        endcase
    end

    // Counter and reload path
    wire logic overflow = quadUp & (count == QOT_CNT_MAX);
    wire logic underflow = quadDown & (count == QOT_CNT_ZERO);
    wire logic [QOT_CNT_W-1:0] wrapValue = ctrl.freeRun ? QOT_CNT_ZERO : reload;
    wire logic [QOT_CNT_W-1:0] underValue = ctrl.freeRun ? QOT_CNT_MAX : reload;

    always_comb begin
        next_reload = reload;
        next_count = count;
        if (wrTimer) begin
            next_reload = hwdata[QOT_CNT_W-1:0];
            if (!running) begin
                next_count = hwdata[QOT_CNT_W-1:0];
            end
        end
        if (overflow) begin
            next_count = wrapValue;
        end else if (underflow) begin
            next_count = underValue;
        end else if (quadUp) begin
            next_count = count + QOT_CNT_ONE;
        end else if (quadDown) begin
            next_count = count - QOT_CNT_ONE;
        end else if (trigger && (state == QOT_ST_ARMED || state == QOT_ST_SHOT)) begin
            next_count = next_reload;
        end else if (shotEnd) begin
            next_count = reload;
        end else if (shotTick) begin
            next_count = count - QOT_CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= QOT_ST_STOP;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count <= QOT_TIMER_RESET;
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reload <= QOT_TIMER_RESET;
        end else begin
            reload <= next_reload;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lastUp <= 1'b0;
        end else if (quadUp || quadDown) begin
            lastUp <= quadUp;
        end
    end

    // Interrupt request and pulse output
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqRequest <= 1'b0;
        end else begin
            irqRequest <= overflow | underflow | shotEnd;
        end
    end

    // Output pin stays undriven in two-phase mode so it can carry phase B
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timerOutPinOut <= 1'b0;
        end else begin
            timerOutPinOut <= ctrl.pulseEn & (next_state == QOT_ST_SHOT);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timerOutPinOe <= 1'b0;
        end else begin
            timerOutPinOe <= ctrl.pulseEn & (ctrl.mode == QOT_MODE_ONESHOT);
        end
    end

endmodule

`default_nettype wire

// ===== qot_timer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module qot_timer_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic timerOutPinOut,
    input wire logic timerOutPinOe,
    input wire logic irqRequest
);
    logic taken;
    logic wrPhase;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    assign taken = hsel && htrans[1] && hready;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) wrPhase <= 1'b0;
        else wrPhase <= taken && hwrite;
    end
    bus_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
    read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    write_nowait_a: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
    wait_single_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
    rdata_hold_a: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("hrdata moved outside read");
    irq_pulse_a: assert property (irqRequest |=> !irqRequest)
        else $error("irq longer than one cycle");
    pulse_gate_a: assert property (timerOutPinOut |-> timerOutPinOe)
        else $error("pulse while pin not driven");
    shot_end_a: assert property (irqRequest && timerOutPinOe |-> !timerOutPinOut)
        else $error("irq while pulse high");
    oe_cause_a: assert property ($changed(timerOutPinOe) |-> $past(wrPhase) || $past(wrPhase, 2))
        else $error("pin enable moved without write");
endmodule
bind qot_timer qot_timer_chk qot_timer_chk_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timerOutPinOut(timerOutPinOut),
    .timerOutPinOe(timerOutPinOe), .irqRequest(irqRequest));
`default_nettype wire

// ===== qot_encoder.sv
`timescale 1ns/100ps
`default_nettype none
module qot_encoder (
    input wire logic sys_clk,
    output logic phaseA,
    output logic phaseB
);
    int idx = 0;
    initial begin
        phaseA = 1'b0;
        phaseB = 1'b0;
    end
    // Gray order 00,01,11,10 is forward; pins only ever driven from here
    task automatic step(input int dir, input int n);
        for (int k = 0; k < n; k++) begin
            idx = (idx + dir + 4) % 4;
            @(posedge sys_clk);
            phaseA <= idx[1];
            phaseB <= idx[1] ^ idx[0];
            repeat (4) @(posedge sys_clk);
        end
    endtask
    // Only valid while A rests high, so the gray position survives
    task automatic pulseA();
        @(posedge sys_clk);
        phaseA <= 1'b0;
        repeat (4) @(posedge sys_clk);
        phaseA <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ===== test_quadrature_and_oneshot_timer.sv
`timescale 1ns/100ps
`default_nettype none
module test_quadrature_and_oneshot_timer;
    import qot_pkg::*;
    logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, otherTov, subClock;
    logic encA, encB, pinB, outPin, oe, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int mismatches = 0;
    int samplesChecked = 0;
    int hiCnt = 0, irqSeen = 0, cyc = 0, h0, i0, t0, per;
    assign pinB = oe ? outPin : encB;
    qot_timer qot_timer_i (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .timerInputPin(encA), .timerOutPinIn(pinB), .timerOutPinOut(outPin),
        .timerOutPinOe(oe), .subClock(subClock), .otherTimerOverflow(otherTov),
        .irqRequest(irq));
    qot_encoder qot_encoder_i (.sys_clk(sys_clk), .phaseA(encA), .phaseB(encB));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Slow sub clock, one rising edge every six system clocks
    initial begin
        subClock <= 1'b0;
        forever begin
            repeat (3) @(posedge sys_clk);
            subClock <= ~subClock;
        end
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (outPin === 1'b1) hiCnt <= hiCnt + 1;
        if (irq === 1'b1) irqSeen <= irqSeen + 1;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", mismatches, samplesChecked);
        if (mismatches == 0 && samplesChecked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic busCycle(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        // Entered just after a rising edge, leaves at the edge ending the data phase
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        busCycle(1'b1, a, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        busCycle(1'b0, a, 32'h00000000, q);
        check(nm, q, e);
    endtask
    task automatic mark();
        h0 = hiCnt;
        i0 = irqSeen;
    endtask
    task automatic settle(input string nm, input int eh, input int ei);
        repeat (16) @(posedge sys_clk);
        check(nm, hiCnt - h0, eh);
        check(nm, irqSeen - i0, ei);
    endtask
    initial begin
        rst <= 1'b1;
        {hsel, hwrite, otherTov, htrans, haddr, hwdata} <= '0;
        hsize <= 3'h2;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd("timer reset", QOT_OFS_TIMER, 32'h00000000);
        rd("ctrl reset", QOT_OFS_CTRL, 32'h00000000);
        rd("unmapped", 8'h0c, 32'h00000000);
        wr(QOT_OFS_TIMER, 32'h00000008);
        rd("stopped load", QOT_OFS_TIMER, 32'h00000008);
        wr(QOT_OFS_CTRL, 32'h00000009);
        wr(QOT_OFS_TIMER, 32'h00000003);
        rd("running load", QOT_OFS_TIMER, 32'h00000008);
        mark();
        qot_encoder_i.step(-1, 9);
        rd("underflow", QOT_OFS_TIMER, 32'h00000003);
        check("underflow irq", irqSeen - i0, 1);
        qot_encoder_i.step(1, 3);
        rd("x4 up", QOT_OFS_TIMER, 32'h00000006);
        rd("status", QOT_OFS_STATUS, 32'h00000005);
        wr(QOT_OFS_CTRL, 32'h00000000);
        wr(QOT_OFS_TIMER, 32'h0000fffd);
        wr(QOT_OFS_CTRL, 32'h00000009);
        wr(QOT_OFS_TIMER, 32'h00000002);
        mark();
        qot_encoder_i.step(1, 3);
        rd("overflow", QOT_OFS_TIMER, 32'h00000002);
        check("overflow irq", irqSeen - i0, 1);
        wr(QOT_OFS_CTRL, 32'h0000000d);
        rd("ctrl readback", QOT_OFS_CTRL, 32'h0000000d);
        mark();
        qot_encoder_i.step(-1, 3);
        rd("free run", QOT_OFS_TIMER, 32'h0000ffff);
        check("free run irq", irqSeen - i0, 1);
        wr(QOT_OFS_CTRL, 32'h00000000);
        wr(QOT_OFS_TIMER, 32'h00000010);
        wr(QOT_OFS_CTRL, 32'h00000001);
        qot_encoder_i.step(1, 4);
        rd("normal up", QOT_OFS_TIMER, 32'h00000011);
        qot_encoder_i.step(-1, 4);
        rd("normal down", QOT_OFS_TIMER, 32'h00000010);
        wr(QOT_OFS_CTRL, 32'h00000000);
        qot_encoder_i.step(1, 4);
        rd("halted", QOT_OFS_TIMER, 32'h00000010);
        wr(QOT_OFS_TIMER, 32'h00000006);
        wr(QOT_OFS_CTRL, 32'h00000043);
        mark();
        wr(QOT_OFS_CTRL, 32'h00000243);
        settle("soft shot", 6, 1);
        mark();
        wr(QOT_OFS_CTRL, 32'h00000243);
        t0 = cyc;
        wr(QOT_OFS_CTRL, 32'h00000243);
        settle("retrigger", cyc - t0 + 6, 1);
        for (int k = 0; k < 2; k++) begin
            wr(QOT_OFS_CTRL, k ? 32'h00000143 : 32'h000000c3);
            mark();
            if (k) begin
                @(posedge sys_clk);
                otherTov <= 1'b1;
                @(posedge sys_clk);
                otherTov <= 1'b0;
            end else begin
                qot_encoder_i.pulseA();
            end
            settle("hw trigger", 6, 1);
        end
        wr(QOT_OFS_CTRL, 32'h00000043);
        mark();
        wr(QOT_OFS_CTRL, 32'h00000243);
        wr(QOT_OFS_CTRL, 32'h00000042);
        repeat (16) @(posedge sys_clk);
        check("stop short", (hiCnt - h0) < 6, 1);
        check("stop irq", irqSeen - i0, 0);
        // Slower sources: two ticks of a free-running prescaler, phase unknown
        for (int s = 1; s < 4; s++) begin
            per = (s == 1) ? QOT_DIV8_LAST + 1 :
                  (s == 2) ? QOT_DIV32_LAST + 1 : 6 * (QOT_DIV32_LAST + 1);
            wr(QOT_OFS_TIMER, 32'h00000002);
            wr(QOT_OFS_CTRL, 32'h00000043 | (s << 4));
            mark();
            wr(QOT_OFS_CTRL, 32'h00000243 | (s << 4));
            repeat (2 * per + 2) @(posedge sys_clk);
            check("slow span", (hiCnt - h0) > per && (hiCnt - h0) <= 2 * per, 1);
            check("slow irq", irqSeen - i0, 1);
        end
        summarize();
    end
    // Whole run is under a thousand cycles
    initial begin
        #300000;
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
